// ---- hw/aes_bank.v ----
// Severity select bits and correctable status flags of a switch port's error logic.
// Assumes events are one-cycle pulses on aclk; sticky_rstn is the power-on reset,
// aresetn the ordinary reset that sticky bits survive.
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/10ps
`include "aes_defs.vh"
module aes_bank (
  input wire aclk,
  input wire aresetn,
  input wire sticky_rstn,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire receive_error_evt,
  input wire bad_transaction_packet_evt,
  input wire bad_link_packet_evt,
  input wire replay_rollover_evt,
  input wire replay_timeout_evt,
  input wire advisory_nonfatal_evt,
  input wire [4:0] uncorr_evt,
  output reg fatal_report,
  output reg nonfatal_report,
  output reg [4:0] uncorr_log,
  output wire irq
);

  reg [11:0] awaddr_q;
  reg aw_held_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg w_held_q;
  reg [4:0] sev_q;
  reg [31:0] ces_q;
  reg [31:0] cmask_q;
  reg [4:0] umask_q;
  reg [31:0] ces_d;
  reg [31:0] evt_vec;
  wire wr_go;
  wire [31:0] wmask;
  wire [4:0] live_evt;

  // Lane mask from byte strobes
  function [31:0] lane_mask;
    input [3:0] strb;
    begin
      lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    end
  endfunction

  // Word-aligned register select
  function hit;
    input [11:0] addr;
    input [11:0] off;
    begin
      hit = (addr[11:2] == off[11:2]);
    end
  endfunction

  // Hold address and data separately; accept in either order
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready = !w_held_q && !s_axi_bvalid;
  assign wr_go = aw_held_q && w_held_q;
  assign wmask = lane_mask(wstrb_q);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AES_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (hit(awaddr_q, `AES_OFF_SEV) || hit(awaddr_q, `AES_OFF_CES) ||
            hit(awaddr_q, `AES_OFF_CMASK) || hit(awaddr_q, `AES_OFF_UMASK))
          s_axi_bresp <= `AES_RESP_OKAY;
        else
          s_axi_bresp <= `AES_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Event vector in status layout
  always @* begin
    evt_vec = 32'h00000000;
    evt_vec[`AES_BIT_RXERR] = receive_error_evt;
    evt_vec[`AES_BIT_BADPKT] = bad_transaction_packet_evt;
    evt_vec[`AES_BIT_BADLNK] = bad_link_packet_evt;
    evt_vec[`AES_BIT_RPLYRO] = replay_rollover_evt;
    evt_vec[`AES_BIT_RTIMEO] = replay_timeout_evt;
    evt_vec[`AES_BIT_ADVNF] = advisory_nonfatal_evt;
  end

  // Status next value: set beats a simultaneous clear
  always @* begin
    ces_d = ces_q;
    if (wr_go && hit(awaddr_q, `AES_OFF_CES))
      ces_d = ces_d & ~(wdata_q & wmask);
    ces_d = (ces_d | evt_vec) & `AES_CES_VALID;
  end

  // Sticky state, only the power-on reset clears it
  always @(posedge aclk) begin
    if (!sticky_rstn) begin
      sev_q <= `AES_SEV_RST;
      ces_q <= `AES_CES_RST;
      cmask_q <= `AES_CMASK_RST;
      umask_q <= `AES_UMASK_RST;
    end else begin
      ces_q <= ces_d;
      if (wr_go && wstrb_q[2]) begin
        if (hit(awaddr_q, `AES_OFF_SEV))
          sev_q <= wdata_q[`AES_SEV_HI:`AES_SEV_LO];
        if (hit(awaddr_q, `AES_OFF_UMASK))
          umask_q <= wdata_q[`AES_SEV_HI:`AES_SEV_LO];
      end
      if (wr_go && hit(awaddr_q, `AES_OFF_CMASK))
        cmask_q <= ((cmask_q & ~wmask) | (wdata_q & wmask)) & `AES_CES_VALID;
    end
  end

  assign live_evt = uncorr_evt & ~umask_q;

  // Severity steering, registered for clean outputs
  always @(posedge aclk) begin
    if (!aresetn) begin
      fatal_report <= 1'b0;
      nonfatal_report <= 1'b0;
      uncorr_log <= 5'h00;
    end else begin
      fatal_report <= |(live_evt & sev_q);
      nonfatal_report <= |(live_evt & ~sev_q);
      uncorr_log <= live_evt;
    end
  end

  // Level interrupt while an unmasked flag stands
  assign irq = |(ces_q & ~cmask_q);

  // Read channel, one word at a time
  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `AES_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `AES_RESP_OKAY;
      if (hit(s_axi_araddr, `AES_OFF_SEV))
        s_axi_rdata <= {11'h000, sev_q, 16'h0000};
      else if (hit(s_axi_araddr, `AES_OFF_CES))
        s_axi_rdata <= ces_q;
      else if (hit(s_axi_araddr, `AES_OFF_CMASK))
        s_axi_rdata <= cmask_q;
      else if (hit(s_axi_araddr, `AES_OFF_UMASK))
        s_axi_rdata <= {11'h000, umask_q, 16'h0000};
      else begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `AES_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // aes_bank

// ---- hw/aes_defs.vh ----
// Offsets, field positions and reset values of the error severity/status bank.
// Included by the bank module; definitions only.
`ifndef AES_DEFS_VH
`define AES_DEFS_VH
`define AES_OFF_SEV 12'h10C
`define AES_OFF_CES 12'h110
`define AES_OFF_CMASK 12'h200
`define AES_OFF_UMASK 12'h204
`define AES_OFF_UEVT 12'h208
`define AES_SEV_LO 16
`define AES_SEV_HI 20
`define AES_SEV_RST 5'h06
`define AES_BIT_RXERR 0
`define AES_BIT_BADPKT 6
`define AES_BIT_BADLNK 7
`define AES_BIT_RPLYRO 8
`define AES_BIT_RTIMEO 12
`define AES_BIT_ADVNF 13
`define AES_CES_VALID 32'h000031C1
`define AES_CES_RST 32'h00000000
`define AES_UMASK_RST 5'h00
`define AES_CMASK_RST 32'h00002000
`define AES_RESP_OKAY 2'h0
`define AES_RESP_SLVERR 2'h2
`endif

// ---- bench/aes_bank_monitor.sv ----
// Port-level checks of the error severity/status bank.
// Assumes it is bound to every aes_bank instance.
`timescale 1ns/10ps
module aes_bank_monitor (
  input wire aclk, aresetn, sticky_rstn, s_axi_awvalid, s_axi_awready,
  input wire s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_arvalid, s_axi_arready,
  input wire s_axi_rvalid, fatal_report, nonfatal_report,
  input wire [31:0] s_axi_rdata,
  input wire [4:0] uncorr_evt, uncorr_log
);
  // Both resets silence the checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !sticky_rstn);
  a_log_cause: assert property (uncorr_log != 5'h00 |->
    (uncorr_log & ~$past(uncorr_evt)) == 5'h00) else $error("log without event");
  a_fatal_logged: assert property (fatal_report |-> uncorr_log != 5'h00)
    else $error("fatal without log");
  a_report_any: assert property (uncorr_log != 5'h00 |-> fatal_report || nonfatal_report)
    else $error("logged event unreported");
  a_rsv_zero: assert property (s_axi_rvalid |->
    (s_axi_rdata & 32'hFFE0CE3E) == 32'h0) else $error("reserved bits set");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready early");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> ##1 s_axi_bvalid) else $error("write not answered");
  a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("awready early");
endmodule // aes_bank_monitor
bind aes_bank aes_bank_monitor u_mon (.*);

// ---- bench/tb.sv ----
// Self-checking bench of the error bank.
// Assumes one aes_bank reached over AXI4-Lite.
`timescale 1ns/10ps
module tb;
reg aclk=0, aresetn=0, sticky_rstn=0, s_axi_awvalid=0, s_axi_wvalid=0, s_axi_arvalid=0;
reg s_axi_bready=1, s_axi_rready=1;
reg [11:0] s_axi_awaddr=0, s_axi_araddr=0;
reg [31:0] s_axi_wdata=0, s=32'h74E1FF59;
reg [3:0] s_axi_wstrb=4'hF;
reg [4:0] uncorr_evt=0;
reg [5:0] ev=0;
wire receive_error_evt=ev[0], bad_transaction_packet_evt=ev[1], bad_link_packet_evt=ev[2];
wire replay_rollover_evt=ev[3], replay_timeout_evt=ev[4], advisory_nonfatal_evt=ev[5];
wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
wire fatal_report, nonfatal_report;
wire [1:0] s_axi_bresp, s_axi_rresp;
wire [31:0] s_axi_rdata;
wire [4:0] uncorr_log;
integer n_errors=0, samples_checked=0, i, t;
reg [33:0] q[$];
localparam [35:0] BP={6'h0D, 6'h0C, 6'h08, 6'h07, 6'h06, 6'h00};
aes_bank u_aes_bank (.*);
// Clock of 50 ns
initial forever #25 aclk = ~aclk;
function [31:0] lf(input [31:0] v);
  lf = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
endfunction
task conclude;
  begin
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
endtask
task chk(input [8*5:1] nm, input [33:0] e, g);
  begin
    samples_checked++;
    if (e !== g) begin
      n_errors++;
      $display("Error %0s exp %h got %h", nm, e, g);
    end
  end
endtask
// Both channels offered together, each released once taken
task wr(input [11:0] a, input [31:0] d);
  begin
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    t = 0;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      t++;
    end while (!s_axi_bvalid && t < 50);
    if (t >= 50) begin
      n_errors++;
      conclude;
    end
  end
endtask
task rd(input [11:0] a, input [33:0] e);
  begin
    q.push_back(e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    t = 0;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      t++;
    end while (!s_axi_rvalid && t < 50);
    if (t >= 50) begin
      n_errors++;
      conclude;
    end
  end
endtask
// One-cycle event pulses, outputs looked at after they land
task pulse(input [5:0] e, input [4:0] u);
  begin
    @(posedge aclk);
    ev <= e;
    uncorr_evt <= u;
    @(posedge aclk);
    ev <= 6'h00;
    uncorr_evt <= 5'h00;
    @(negedge aclk);
  end
endtask
// Oldest note against each accepted read answer
always @(posedge aclk)
  if (s_axi_rvalid && s_axi_rready) chk("rdata", q.pop_front(), {s_axi_rresp, s_axi_rdata});
initial begin
  repeat (20) @(posedge aclk);
  aresetn <= 1'h1;
  sticky_rstn <= 1'h1;
  rd(12'h10C, 34'h000060000);
  rd(12'h110, 34'h0);
  rd(12'h3F0, 34'h200000000);
  for (i = 0; i < 6; i++) begin
    pulse(6'h01 << i, 5'h00);
    rd(12'h110, 34'h1 << BP[i*6+:6]);
    wr(12'h110, 32'hFFFFFFFF);
    rd(12'h110, 34'h0);
  end
  pulse(6'h01, 5'h00);
  chk("irq", 1'h1, irq);
  wr(12'h200, 32'h1);
  chk("irq", 1'h0, irq);
  // Ordinary reset must leave sticky flags alone
  @(posedge aclk) aresetn <= 1'h0;
  @(posedge aclk) aresetn <= 1'h1;
  rd(12'h110, 34'h1);
  for (i = 0; i < 4; i++) begin
    s = lf(s);
    wr(12'h10C, s);
    rd(12'h10C, {2'h0, s & 32'h001F0000});
    pulse(6'h00, 5'h1F);
    chk("rep", {|s[20:16], ~&s[20:16], 5'h1F}, {fatal_report, nonfatal_report, uncorr_log});
  end
  wr(12'h204, 32'h001F0000);
  pulse(6'h00, 5'h1F);
  chk("mask", 34'h0, {fatal_report, nonfatal_report, uncorr_log});
  conclude;
end
endmodule // tb
